// ### design/wdu_params.svh
`ifndef WDU_PARAMS_SVH
`define WDU_PARAMS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define WDU_BASE_ADDR      32'h4000_0400
`define WDU_OFF_RELOAD     32'h0000_0000
`define WDU_OFF_CTRL       32'h0000_0004
`define WDU_OFF_RESTART    32'h0000_0008
`define WDU_OFF_COUNT      32'h0000_000c

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define WDU_CTRL_EN_BIT    0
`define WDU_CTRL_FLAG_BIT  1
`define WDU_RELOAD_RESET   16'h000f
`define WDU_COUNT_RESET    16'h000f

// ----------------------------------------
// Timing
// ----------------------------------------
`define WDU_SLOW_PER_COUNT 6'h21

`endif

// ### design/wdu_pkg.sv
package wdu_pkg;

    typedef struct packed {
        logic [31:0] addr;
        logic        wr;
        logic        rd;
        logic [31:0] wdata;
    } wdu_req_s;

    typedef struct packed {
        logic [15:0] reload;
        logic        enable;
        logic        flag;
        logic [15:0] count;
        logic [5:0]  presc;
        logic        sync_a;
        logic        sync_b;
        logic        sync_c;
        logic        event_pulse;
        logic        event_seen;
        logic [31:0] rdata;
    } wdu_state_s;

endpackage

// ### design/wdu_watchdog_unit.sv
`timescale 1ns/10ps
`include "wdu_params.svh"

// What this block does
// RL1 - Four word registers at base 4000_0400h
// RL2 - Writing reload value reloads the counter
// RL3 - Underflow sets status flag bit 1
// RL4 - Writing one clears flag, zero ignored
// RL5 - Bit 0 enables; resets to zero
// RL6 - Restart register stores nothing, reads zero
// RL7 - Restart write when enabled reloads counter
// RL8 - Restart write when disabled is ignored
// RL9 - Count register read-only, shows counter
// RL10 - Decrement once per 33 slow clocks
// RL11 - Underflow raises event and sets flag
// RL12 - Event pulse; seen only cleared by reset
// RL13 - Disable freezes counter and prescaler
// RL14 - Register access on core clock, reads answer one cycle later; slow clock synchronised
module wdu_watchdog_unit
    import wdu_pkg::*;
(
    input  wire logic        core_clk_in,
    input  wire logic        rstn_in,
    input  wire logic        slow_count_clock_in,
    input  wire wdu_req_s    req_in,
    output logic [31:0]      rdata_out,
    output logic             enable_out,
    output logic [15:0]      count_out,
    output logic             event_pulse_out,
    output logic             event_seen_out
);

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    function automatic logic wdu_hit(input logic [31:0] addr, input logic [31:0] off);
        wdu_hit = (addr == (`WDU_BASE_ADDR + off));
    endfunction

    wdu_state_s s_q;
    wdu_state_s s_d;

    logic wr_reload;
    logic wr_ctrl;
    logic wr_restart;
    logic slow_tick;

    assign wr_reload  = req_in.wr && wdu_hit(req_in.addr, `WDU_OFF_RELOAD);   // RL1
    assign wr_ctrl    = req_in.wr && wdu_hit(req_in.addr, `WDU_OFF_CTRL);     // RL1
    assign wr_restart = req_in.wr && wdu_hit(req_in.addr, `WDU_OFF_RESTART);  // RL1
    // Edge of the slow clock, read only after the second stage
    assign slow_tick  = s_q.sync_b && !s_q.sync_c;                            // RL14

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        s_d = s_q;
        s_d.sync_a = slow_count_clock_in;
        s_d.sync_b = s_q.sync_a;
        s_d.sync_c = s_q.sync_b;
        s_d.event_pulse = 1'b0;

        // Counting only on a slow tick while enabled; otherwise counter and prescaler hold
        if (s_q.enable && slow_tick)                                          // RL13
        begin
            if (s_q.presc == `WDU_SLOW_PER_COUNT - 6'h01)                      // RL10
            begin
                s_d.presc = 6'h00;
                if (s_q.count == 16'h0000)                                    // RL11
                begin
                    s_d.event_pulse = 1'b1;                                   // RL12
                    s_d.event_seen  = 1'b1;                                   // RL12
                    s_d.flag        = 1'b1;                                   // RL3
                    s_d.count       = s_q.reload;
                end
                else
                begin
                    s_d.count = s_q.count - 16'h0001;                         // RL10
                end
            end
            else
            begin
                s_d.presc = s_q.presc + 6'h01;
            end
        end

        if (wr_restart && s_q.enable)                                         // RL7 RL8
        begin
            s_d.count = s_q.reload;
            s_d.presc = 6'h00;
        end

        if (wr_reload)                                                        // RL2
        begin
            s_d.reload = req_in.wdata[15:0];
            s_d.count  = req_in.wdata[15:0];
            s_d.presc  = 6'h00;
        end

        if (wr_ctrl)
        begin
            s_d.enable = req_in.wdata[`WDU_CTRL_EN_BIT];                      // RL5
            // Set from an underflow in the same cycle wins over clear
            if (req_in.wdata[`WDU_CTRL_FLAG_BIT] && !s_d.event_pulse)         // RL4
                s_d.flag = 1'b0;
        end

        // Reads answer one cycle later from flops; unmapped reads zero
        s_d.rdata = 32'h0000_0000;
        if (req_in.rd)                                                        // RL14
        begin
            if (wdu_hit(req_in.addr, `WDU_OFF_RELOAD))
                s_d.rdata = {16'h0000, s_q.reload};
            else if (wdu_hit(req_in.addr, `WDU_OFF_CTRL))
                s_d.rdata = {30'h0000_0000, s_q.flag, s_q.enable};
            else if (wdu_hit(req_in.addr, `WDU_OFF_RESTART))
                s_d.rdata = 32'h0000_0000;                                    // RL6
            else if (wdu_hit(req_in.addr, `WDU_OFF_COUNT))
                s_d.rdata = {16'h0000, s_q.count};                            // RL9
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge core_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            s_q        <= '0;
            s_q.reload <= `WDU_RELOAD_RESET;
            s_q.count  <= `WDU_COUNT_RESET;
            s_q.enable <= 1'b0;                                               // RL5
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // All straight from flops, so the controller reset sees no glitch
    assign rdata_out           = s_q.rdata;
    assign enable_out          = s_q.enable;
    assign count_out           = s_q.count;
    assign event_pulse_out     = s_q.event_pulse;
    assign event_seen_out      = s_q.event_seen;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);

    a_reload_write: assert property (wr_reload |=> count_out == $past(req_in.wdata[15:0])) // RL2
        else $error("reload write did not load counter");
    a_restart_off: assert property (wr_restart && !enable_out && !wr_reload && !wr_ctrl // RL8
        |=> count_out == $past(count_out))
        else $error("restart while disabled changed counter");
    a_restart_on: assert property (wr_restart && enable_out && !wr_reload // RL7
        |=> count_out == $past(s_q.reload))
        else $error("restart did not reload counter");
    a_frozen_count: assert property (!enable_out && !wr_reload // RL13
        |=> $stable(count_out) && $stable(s_q.presc))
        else $error("counter moved while disabled");
    a_event_flag: assert property (event_pulse_out |-> s_q.flag && event_seen_out) // RL3
        else $error("underflow without flag");
    a_pulse_single: assert property (event_pulse_out |=> !event_pulse_out) // RL12
        else $error("event pulse longer than one cycle");
    a_seen_sticky: assert property (event_seen_out |=> event_seen_out) // RL12
        else $error("event indication dropped");
    a_flag_clear: assert property (wr_ctrl && req_in.wdata[1] && !s_d.event_pulse // RL4
        |=> !s_q.flag)
        else $error("flag not cleared by one write");
    a_flag_keep: assert property (s_q.flag && !(wr_ctrl && req_in.wdata[1]) |=> s_q.flag) // RL4
        else $error("flag lost without clear");
    a_restart_read: assert property (req_in.rd && wdu_hit(req_in.addr, `WDU_OFF_RESTART) // RL6
        |=> rdata_out == 32'h0000_0000)
        else $error("restart register read nonzero");
    a_count_read: assert property (req_in.rd && wdu_hit(req_in.addr, `WDU_OFF_COUNT) // RL9
        |=> rdata_out[15:0] == $past(count_out))
        else $error("count read mismatch");

    // ----------------------------------------
    // Register access checks
    // ----------------------------------------
    a_enable_write: assert property (wr_ctrl |=> enable_out == $past(req_in.wdata[0])) // RL5
        else $error("enable bit not written");
    a_ctrl_read: assert property (req_in.rd && wdu_hit(req_in.addr, `WDU_OFF_CTRL) // RL3 RL5
        |=> rdata_out == {30'h0000_0000, $past(s_q.flag), $past(enable_out)})
        else $error("control read mismatch");
    a_reload_read: assert property (req_in.rd && wdu_hit(req_in.addr, `WDU_OFF_RELOAD) // RL2
        |=> rdata_out == {16'h0000, $past(s_q.reload)})
        else $error("reload read mismatch");
    a_unmapped_read: assert property (req_in.rd // RL1
        && !wdu_hit(req_in.addr, `WDU_OFF_RELOAD) && !wdu_hit(req_in.addr, `WDU_OFF_CTRL)
        && !wdu_hit(req_in.addr, `WDU_OFF_RESTART) && !wdu_hit(req_in.addr, `WDU_OFF_COUNT)
        |=> rdata_out == 32'h0000_0000)
        else $error("unmapped read nonzero");
    a_rdata_idle: assert property (!req_in.rd |=> rdata_out == 32'h0000_0000) // RL14
        else $error("read data held without a read");

    // ----------------------------------------
    // Counter checks
    // ----------------------------------------
    a_presc_range: assert property (s_q.presc < `WDU_SLOW_PER_COUNT) // RL10
        else $error("prescaler past its wrap point");
    a_count_hold: assert property (!wr_reload && !(wr_restart && enable_out) // RL10
        && !(enable_out && slow_tick) |=> $stable(count_out))
        else $error("counter moved without a tick");
    a_count_step: assert property (!wr_reload && !(wr_restart && enable_out) // RL10
        && count_out != 16'h0000 |=> count_out == $past(count_out)
        || count_out == $past(count_out) - 16'h0001)
        else $error("counter stepped by more than one");

    // ----------------------------------------
    // Underflow checks
    // ----------------------------------------
    a_underflow_event: assert property (enable_out && slow_tick && count_out == 16'h0000 // RL11
        && s_q.presc == `WDU_SLOW_PER_COUNT - 6'h01 |=> event_pulse_out && s_q.flag)
        else $error("underflow did not raise the event");
    a_underflow_reload: assert property (event_pulse_out |-> count_out == s_q.reload) // RL11
        else $error("underflow did not reload counter");

endmodule

// ### bench/watchdog_timer_regs_tb.sv
`timescale 1ns/10ps
`include "wdu_params.svh"
module watchdog_timer_regs_tb
    import wdu_pkg::*;
;
    logic        core_clk_in         = 1'b0;
    logic        rstn_in             = 1'b0;
    logic        slow_count_clock_in = 1'b0;
    wdu_req_s    req_in              = '0;
    logic [31:0] rdata_out;
    logic        enable_out;
    logic [15:0] count_out;
    logic        pulse;
    logic        seen;
    int          fails               = 0;
    int          samples_checked     = 0;
    int          sdiv                = 0;
    int          n;

    always #2.5 core_clk_in = ~core_clk_in;

    // Slow tick every 8 core cycles; far above 32 kHz to keep the run short
    always @(negedge core_clk_in)
    begin
        sdiv <= (sdiv + 1) % 8;
        slow_count_clock_in <= (sdiv < 4);
    end

    wdu_watchdog_unit dut (
        .core_clk_in         (core_clk_in),
        .rstn_in             (rstn_in),
        .slow_count_clock_in (slow_count_clock_in),
        .req_in              (req_in),
        .rdata_out           (rdata_out),
        .enable_out          (enable_out),
        .count_out           (count_out),
        .event_pulse_out     (pulse),
        .event_seen_out      (seen)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e)
        begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic wr(input logic [31:0] off, input logic [31:0] d);
        @(negedge core_clk_in);
        req_in.addr = `WDU_BASE_ADDR + off;
        req_in.wdata = d;
        req_in.wr = 1'b1;
        @(negedge core_clk_in);
        req_in.wr = 1'b0;
    endtask

    // Read data is registered: taken at one edge, shown until the next
    task automatic rdchk(input string nm, input logic [31:0] off, input logic [31:0] e);
        @(negedge core_clk_in);
        req_in.addr = `WDU_BASE_ADDR + off;
        req_in.rd = 1'b1;
        @(negedge core_clk_in);
        req_in.rd = 1'b0;
        chk(nm, rdata_out, e);
    endtask

    task automatic idle(input int c);
        repeat (c) @(negedge core_clk_in);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        rdchk("reload", `WDU_OFF_RELOAD, 32'h0000_000f);
        rdchk("ctrl", `WDU_OFF_CTRL, 32'h0000_0000);
        rdchk("restart", `WDU_OFF_RESTART, 32'h0000_0000);
        rdchk("count", `WDU_OFF_COUNT, 32'h0000_000f);
        rdchk("unmapped", 32'h0000_0010, 32'h0000_0000);
        $display("test reset done");
    endtask

    task automatic t_count;
        wr(`WDU_OFF_RELOAD, 32'h0000_0020);
        chk("count after load", 32'(count_out), 32'h0000_0020);
        wr(`WDU_OFF_COUNT, 32'h0000_0005);
        rdchk("count ro", `WDU_OFF_COUNT, 32'h0000_0020);
        idle(300);
        chk("count idle", 32'(count_out), 32'h0000_0020);
        wr(`WDU_OFF_CTRL, 32'h0000_0001);
        chk("enable", 32'(enable_out), 32'h0000_0001);
        idle(250);
        chk("count early", 32'(count_out), 32'h0000_0020);
        idle(30);
        chk("count step", 32'(count_out), 32'h0000_001f);
        wr(`WDU_OFF_CTRL, 32'h0000_0000);
        idle(300);
        chk("count frozen", 32'(count_out), 32'h0000_001f);
        wr(`WDU_OFF_RESTART, 32'h0000_00ff);
        chk("restart off", 32'(count_out), 32'h0000_001f);
        wr(`WDU_OFF_CTRL, 32'h0000_0001);
        wr(`WDU_OFF_RESTART, 32'h0000_00ff);
        chk("restart on", 32'(count_out), 32'h0000_0020);
        $display("test count done");
    endtask

    task automatic t_underflow;
        wr(`WDU_OFF_RELOAD, 32'h0000_0001);
        n = 0;
        while (pulse !== 1'b1 && n < 700)
        begin
            idle(1);
            n++;
        end
        if (n >= 700)
        begin
            fails++;
            wrap_up();
        end
        chk("underflow time", 32'(n >= 515 && n <= 545), 32'h0000_0001);
        idle(1);
        chk("pulse width", 32'(pulse), 32'h0000_0000);
        chk("seen", 32'(seen), 32'h0000_0001);
        rdchk("flag set", `WDU_OFF_CTRL, 32'h0000_0003);
        wr(`WDU_OFF_CTRL, 32'h0000_0001);
        rdchk("flag kept", `WDU_OFF_CTRL, 32'h0000_0003);
        wr(`WDU_OFF_CTRL, 32'h0000_0003);
        rdchk("flag clear", `WDU_OFF_CTRL, 32'h0000_0001);
        chk("seen sticky", 32'(seen), 32'h0000_0001);
        $display("test underflow done");
    endtask

    initial
    begin
        idle(10);
        rstn_in = 1'b1;
        t_reset();
        t_count();
        t_underflow();
        wrap_up();
    end
endmodule
